// ### pdm_mic.sv
// Microphone end: channel latch, rate detection, modulator, line driver
`timescale 1ns/100ps
module pdm_mic
    import pdm_pkg::*;
#(
    parameter int WAKE_COUNT    = WAKE_CYC,
    parameter int STARTUP_COUNT = STARTUP_CYC
) (
    input  wire logic                clk_sys,
    input  wire logic                srst,
    input  wire logic                select_pin,
    input  wire logic [SAMPLE_W-1:0] sample_data,
    input  wire logic                sample_valid,
    output logic                     sample_ready,
    pdm_link_if.mic                  link,
    output logic                     low_power_listening_state,
    output logic                     sleeping,
    output logic                     settled
);
    localparam logic signed [INT_W-1:0] FS_POS = INT_W'(FULL_SCALE);
    localparam logic signed [INT_W-1:0] FS_NEG = -INT_W'(FULL_SCALE);
    localparam logic signed [INT_W-1:0] OFS    = INT_W'(DC_OFFSET);
    localparam logic signed [INT_W:0]   LIM_P  = (INT_W+1)'(SAT_LIM);
    localparam logic signed [INT_W:0]   LIM_N  = -(INT_W+1)'(SAT_LIM);
    localparam logic [WAIT_W-1:0] WAKE_LOAD = WAIT_W'(WAKE_COUNT);
    localparam logic [WAIT_W-1:0] START_LOAD = WAIT_W'(STARTUP_COUNT);

    typedef struct packed {
        dev_state_t                    st;
        mode_t                         mode;
        logic [1:0]                    lat_cnt;
        logic                          is_left;
        logic                          sel_s1;
        logic                          sel_s2;
        logic                          ck_s1;
        logic                          ck_s2;
        logic                          ck_s3;
        logic [PER_W-1:0]              per_cnt;
        logic [WAIT_W-1:0]             warm;
        logic [ORDER-1:0][INT_W-1:0]   integ;
        logic [SAMPLE_W-1:0]           smp;
        logic                          dat;
        logic                          oe;
        logic                          settled;
        logic                          lp;
        logic                          slp;
    } mic_state_t;

    mic_state_t              s_q;
    mic_state_t              s_d;
    logic                    rise;
    logic                    fall;
    logic                    launch;
    logic                    release_edge;
    logic                    pop;
    logic [SAMPLE_W-1:0]     fifo_data;
    logic                    fifo_valid;
    logic signed [INT_W-1:0] xin;
    logic signed [INT_W-1:0] drive;
    logic signed [INT_W-1:0] fb;
    logic signed [INT_W:0]   acc;

    //--------------------------------------------------------------------
    // Helpers
    //--------------------------------------------------------------------
    // Clamp an integrator so overload distorts instead of wrapping
    function automatic logic [INT_W-1:0] sat(input logic signed [INT_W:0] v);
        if (v > LIM_P) begin
            return LIM_P[INT_W-1:0];
        end else if (v < LIM_N) begin
            return LIM_N[INT_W-1:0];
        end
        return v[INT_W-1:0];
    endfunction

    // Period to mode; anything not near the low-power rate is standard
    function automatic mode_t classify(input logic [PER_W-1:0] per);
        if (per >= LP_MIN_CYC && per <= LP_MAX_CYC) begin
            return MODE_LP;
        end
        return MODE_STD;
    endfunction

    //--------------------------------------------------------------------
    // Sample buffer
    //--------------------------------------------------------------------
    sample_fifo #(
        .WIDTH (SAMPLE_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .srst      (srst),
        .in_data   (sample_data),
        .in_valid  (sample_valid),
        .in_ready  (sample_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (pop)
    );

    //--------------------------------------------------------------------
    // Bit clock edges
    //--------------------------------------------------------------------
    assign rise = s_q.ck_s2 & ~s_q.ck_s3;
    assign fall = ~s_q.ck_s2 & s_q.ck_s3;
    // One launch edge per period keeps a mono line changing on one edge
    assign launch       = s_q.is_left ? fall : rise;
    assign release_edge = s_q.is_left ? rise : fall;

    //--------------------------------------------------------------------
    // Next state
    //--------------------------------------------------------------------
    always_comb begin
        s_d    = s_q;
        pop    = 1'b0;
        xin    = '0;
        drive  = '0;
        fb     = '0;
        acc    = '0;
        s_d.sel_s1 = select_pin;
        s_d.sel_s2 = s_q.sel_s1;
        s_d.ck_s1  = link.bclk;
        s_d.ck_s2  = s_q.ck_s1;
        s_d.ck_s3  = s_q.ck_s2;
        if (rise) begin
            s_d.per_cnt = PER_ONE;
        end else if (s_q.per_cnt != SLEEP_CYC) begin
            s_d.per_cnt = s_q.per_cnt + 1'b1;
        end
        unique case (s_q.st)
            ST_LATCH: begin
                // Pin is taken once; later changes are never looked at
                if (s_q.lat_cnt == SEL_WAIT) begin
                    s_d.is_left = s_q.sel_s2;
                    s_d.st      = ST_WARM;
                    s_d.warm    = START_LOAD;
                    s_d.mode    = MODE_STD;
                end else begin
                    s_d.lat_cnt = s_q.lat_cnt + 1'b1;
                end
            end
            ST_SLEEP: begin
                s_d.oe = 1'b0;
                if (rise) begin
                    s_d.st   = ST_WARM;
                    s_d.warm = WAKE_LOAD;
                    s_d.mode = MODE_STD;
                end
            end
            ST_WARM, ST_RUN: begin
                if (s_q.per_cnt == SLEEP_CYC) begin
                    s_d.st      = ST_SLEEP;
                    s_d.mode    = MODE_SLEEP;
                    s_d.oe      = 1'b0;
                    s_d.settled = 1'b0;
                    s_d.integ   = '0;
                end else begin
                    if (rise) begin
                        s_d.mode = classify(s_q.per_cnt);
                    end
                    if (s_q.st == ST_WARM) begin
                        if (s_q.warm == '0) begin
                            s_d.st      = ST_RUN;
                            s_d.settled = 1'b1;
                        end else begin
                            s_d.warm = s_q.warm - 1'b1;
                        end
                    end
                    if (launch) begin
                        pop = (s_q.st == ST_RUN) & fifo_valid;
                        if (pop) begin
                            s_d.smp = fifo_data;
                        end
                        // Muted input while settling gives a zero pattern
                        if (s_q.st == ST_RUN) begin
                            xin = INT_W'($signed(s_q.smp)) + OFS;
                        end else begin
                            xin = OFS;
                        end
                        if (xin > FS_POS) begin
                            xin = FS_POS;
                        end
                        fb = s_q.dat ? FS_POS : FS_NEG;
                        for (int k = 0; k < ORDER; k++) begin
                            if (k == 0) begin
                                drive = xin;
                            end else begin
                                drive = $signed(s_q.integ[k-1]) >>> 1;
                            end
                            acc = (INT_W+1)'($signed(s_q.integ[k]))
                                + (INT_W+1)'(drive)
                                - (INT_W+1)'(fb);
                            s_d.integ[k] = sat(acc);
                        end
                        s_d.dat = ~s_d.integ[ORDER-1][INT_W-1];
                        s_d.oe  = 1'b1;
                    end else if (release_edge) begin
                        s_d.oe = 1'b0;
                    end
                end
            end
        endcase
        // Status outputs come from flops loaded from the next state, so they change in the same cycle as the state
        s_d.lp  = s_d.mode == MODE_LP;
        s_d.slp = s_d.st == ST_SLEEP;
    end

    //--------------------------------------------------------------------
    // State register
    //--------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign link.mic_dat              = s_q.dat;
    assign link.mic_oe               = s_q.oe;
    assign low_power_listening_state = s_q.lp;
    assign sleeping                  = s_q.slp;
    assign settled                   = s_q.settled;
endmodule // pdm_mic

// ### pdm_pkg.sv
// Shared constants, types and timing figures for the PDM microphone link
//------------------------------------------------------------------------
// Functional notes
//------------------------------------------------------------------------
// Functional notes
// - Data pin carries fourth-order one-bit stream
// - Left launches on falling, right on rising
// - Release line during the other half period
// - Left and right share line and clock
// - Channel pin latched once, kept fixed
// - Pin low is right, high is left
// - Mono device changes output on one edge
// - Density of ones encodes amplitude
// - Small positive offset, receiver removes it
// - Low-power rate selects listening mode
// - Slow clock means sleep, line released
// - Settled within wake-up limit after sleep
// - Settled within start-up limit after power
// - Modulator saturates at full scale, never wraps
// - Receiver decimator needs eighteen-bit resolution
// - Receiver makes clock, splits slots, filters
// - Host sleeps both devices with slower clock
// - Drive after launch edge, release after next
package pdm_pkg;

    //--------------------------------------------------------------------
    // Clock and timing
    //--------------------------------------------------------------------
    localparam int SYS_CLK_HZ     = 100_000_000;
    localparam int LP_RATE_HZ     = 768_000;
    localparam int SLEEP_RATE_HZ  = 200_000;
    localparam int LP_TOL_PCT     = 5;
    localparam int WAKE_MS        = 10;
    localparam int STARTUP_MS     = 20;
    localparam int WAKE_CYC       = SYS_CLK_HZ / 1000 * WAKE_MS;
    localparam int STARTUP_CYC    = SYS_CLK_HZ / 1000 * STARTUP_MS;
    localparam int WAIT_W         = 22;
    localparam int PER_W          = 10;
    localparam int LP_NOM_CYC     = SYS_CLK_HZ / LP_RATE_HZ;
    localparam logic [PER_W-1:0] SLEEP_CYC =
        PER_W'(SYS_CLK_HZ / SLEEP_RATE_HZ);
    localparam logic [PER_W-1:0] LP_MIN_CYC =
        PER_W'(LP_NOM_CYC * (100 - LP_TOL_PCT) / 100);
    localparam logic [PER_W-1:0] LP_MAX_CYC =
        PER_W'(LP_NOM_CYC * (100 + LP_TOL_PCT) / 100);
    localparam logic [PER_W-1:0] PER_ONE = PER_W'(1);
    localparam logic [1:0]       SEL_WAIT = 2'h2;

    //--------------------------------------------------------------------
    // Codec clock divider, half periods in system cycles
    //--------------------------------------------------------------------
    localparam int DIV_W      = 8;
    localparam int STD_HALF   = 21;
    localparam int LP_HALF    = SYS_CLK_HZ / LP_RATE_HZ / 2;

    //--------------------------------------------------------------------
    // Modulator and data path
    //--------------------------------------------------------------------
    localparam int SAMPLE_W   = 16;
    localparam int FIFO_DEPTH = 8;
    localparam int ORDER      = 4;
    localparam int INT_W      = 24;
    localparam int FULL_SCALE = 32767;
    localparam int SAT_LIM    = FULL_SCALE * 8;
    localparam int DC_PCT     = 3;
    localparam int DC_OFFSET  = FULL_SCALE * DC_PCT / 100;
    localparam int PCM_W      = 18;
    localparam int DECIM      = 64;
    localparam int HP_SHIFT   = 8;
    localparam int SLOT_LEFT  = 1;
    localparam int SLOT_RIGHT = 0;

    typedef enum logic [1:0] {
        MODE_SLEEP = 2'b00,
        MODE_STD   = 2'b01,
        MODE_LP    = 2'b10
    } mode_t;

    typedef enum logic [1:0] {
        ST_LATCH = 2'b00,
        ST_SLEEP = 2'b01,
        ST_WARM  = 2'b10,
        ST_RUN   = 2'b11
    } dev_state_t;

endpackage

// ### pdm_link_if.sv
// Shared PDM clock and data line between microphone and codec
`timescale 1ns/100ps
interface pdm_link_if;
    logic bclk;
    logic mic_dat;
    logic mic_oe;
    logic peer_dat;
    logic peer_oe;
    logic held = 1'b0;
    logic dat;
    logic clash;

    // No pull resistor: a released line shows the inverse of its last
    // level, so a sample taken after release reads a wrong bit
    always_latch begin
        if (mic_oe | peer_oe) begin
            held <= mic_oe ? mic_dat : peer_dat;
        end
    end

    assign dat   = mic_oe ? mic_dat : (peer_oe ? peer_dat : ~held);
    assign clash = mic_oe & peer_oe;

    modport mic   (input bclk, output mic_dat, output mic_oe);
    modport codec (output bclk, input dat);
endinterface

// ### sample_fifo.sv
// Flip-flop FIFO feeding audio samples to the modulator
`timescale 1ns/100ps
module sample_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_sys,
    input  wire logic             srst,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
    localparam logic [AW:0]   FULL = (AW+1)'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr;
        logic [AW-1:0]               rd;
        logic [AW:0]                 cnt;
        logic                        rdy;
        logic                        vld;
    } fifo_state_t;

    fifo_state_t s_q;
    fifo_state_t s_d;
    logic        push;
    logic        pop;

    always_comb begin
        s_d  = s_q;
        push = in_valid & s_q.rdy;
        pop  = out_ready & s_q.vld;
        if (push) begin
            s_d.mem[s_q.wr] = in_data;
            s_d.wr = (s_q.wr == LAST) ? '0 : s_q.wr + 1'b1;
        end
        if (pop) begin
            s_d.rd = (s_q.rd == LAST) ? '0 : s_q.rd + 1'b1;
        end
        s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
        s_d.rdy = s_d.cnt != FULL;
        s_d.vld = s_d.cnt != '0;
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s_q     <= '0;
            s_q.rdy <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign in_ready  = s_q.rdy;
    assign out_valid = s_q.vld;
    assign out_data  = s_q.mem[s_q.rd];
endmodule // sample_fifo

// ### pdm_codec.sv
// Codec end: bit clock divider, slot sampling, decimation, DC removal
`timescale 1ns/100ps
module pdm_codec
    import pdm_pkg::*;
#(
    parameter int STD_HALF_CYC = STD_HALF,
    parameter int LP_HALF_CYC  = LP_HALF,
    parameter int DECIM_LEN    = DECIM
) (
    input  wire logic             clk_sys,
    input  wire logic             srst,
    input  wire mode_t            mode_req,
    pdm_link_if.codec             link,
    output logic                  bit_left,
    output logic                  bit_right,
    output logic                  bit_valid,
    output logic [PCM_W-1:0]      pcm_left,
    output logic [PCM_W-1:0]      pcm_right,
    output logic                  pcm_valid
);
    localparam int DEC_W = $clog2(DECIM_LEN);
    localparam logic [DEC_W-1:0] DEC_LAST = DEC_W'(DECIM_LEN - 1);
    localparam logic [PCM_W-1:0] ONE_P = PCM_W'(1);

    typedef struct packed {
        logic [DIV_W-1:0]            div;
        logic                        bclk;
        logic                        dat_s1;
        logic                        dat_s2;
        logic [1:0]                  bits;
        logic                        bit_vld;
        logic [DEC_W-1:0]            dcnt;
        logic [1:0][PCM_W-1:0]       acc;
        logic [1:0][PCM_W-1:0]       dc;
        logic [1:0][PCM_W-1:0]       pcm;
        logic                        pcm_vld;
    } codec_state_t;

    codec_state_t            s_q;
    codec_state_t            s_d;
    logic [DIV_W-1:0]        half_last;
    logic signed [PCM_W-1:0] hp;

    always_comb begin
        s_d       = s_q;
        hp        = '0;
        half_last = (mode_req == MODE_LP) ? DIV_W'(LP_HALF_CYC - 1)
                                          : DIV_W'(STD_HALF_CYC - 1);
        s_d.dat_s1  = link.dat;
        s_d.dat_s2  = s_q.dat_s1;
        s_d.bit_vld = 1'b0;
        s_d.pcm_vld = 1'b0;
        if (mode_req == MODE_SLEEP && !s_q.bclk) begin
            // Stopped clock sends the device to sleep
            // Stopping only in the low half leaves no runt pulse
            s_d.div = '0;
        end else if (s_q.div >= half_last) begin
            // A half cut short by a mode change ends without wrapping
            s_d.div  = '0;
            s_d.bclk = ~s_q.bclk;
            // Synchronised line still shows the slot that is ending
            if (!s_q.bclk) begin
                s_d.bits[SLOT_LEFT] = s_q.dat_s2;
            end else begin
                s_d.bits[SLOT_RIGHT] = s_q.dat_s2;
                s_d.bit_vld          = 1'b1;
            end
        end else begin
            s_d.div = s_q.div + 1'b1;
        end
        if (s_q.bit_vld) begin
            s_d.dcnt = s_q.dcnt + 1'b1;
            for (int c = 0; c < 2; c++) begin
                // Box decimator; width carries the resolution
                s_d.acc[c] = s_q.bits[c] ? s_q.acc[c] + ONE_P
                                         : s_q.acc[c] - ONE_P;
                if (s_q.dcnt == DEC_LAST) begin
                    hp = $signed(s_d.acc[c]) - $signed(s_q.dc[c]);
                    s_d.pcm[c] = hp;
                    s_d.dc[c]  = s_q.dc[c] + PCM_W'(hp >>> HP_SHIFT);
                    s_d.acc[c] = '0;
                end
            end
            s_d.pcm_vld = s_q.dcnt == DEC_LAST;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign link.bclk = s_q.bclk;
    assign bit_left  = s_q.bits[SLOT_LEFT];
    assign bit_right = s_q.bits[SLOT_RIGHT];
    assign bit_valid = s_q.bit_vld;
    assign pcm_left  = s_q.pcm[SLOT_LEFT];
    assign pcm_right = s_q.pcm[SLOT_RIGHT];
    assign pcm_valid = s_q.pcm_vld;
endmodule // pdm_codec

// ### pdm_link_props.sv
// Concurrent checks on the shared PDM clock and data line
`timescale 1ns/100ps
module pdm_link_props (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic bclk,
    input wire logic mic_dat,
    input wire logic mic_oe,
    input wire logic peer_dat,
    input wire logic peer_oe,
    input wire logic clash
);
    //--------------------------------------------------------------------
    // Cycles since the bit clock last moved, saturating
    //--------------------------------------------------------------------
    logic       bclk_q;
    logic [9:0] idle_q;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            bclk_q <= 1'b0;
            idle_q <= 10'h000;
        end else begin
            bclk_q <= bclk;
            if (bclk != bclk_q) begin
                idle_q <= 10'h000;
            end else if (idle_q != 10'h3FF) begin
                idle_q <= idle_q + 10'h001;
            end
        end
    end

    //--------------------------------------------------------------------
    // Properties
    //--------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    property p_no_clash;
        !clash;
    endproperty
    a_no_clash: assert property (p_no_clash)
        else $error("both ends drive the line");
    property p_right_launch;
        $rose(mic_oe) |-> $past(bclk, 3);
    endproperty
    a_right_launch: assert property (p_right_launch)
        else $error("right end launched off the rising edge");
    property p_left_launch;
        $rose(peer_oe) |-> !$past(bclk, 3);
    endproperty
    a_left_launch: assert property (p_left_launch)
        else $error("left end launched off the falling edge");
    property p_right_release;
        $fell(bclk) |-> ##[1:6] !mic_oe;
    endproperty
    a_right_release: assert property (p_right_release)
        else $error("right end held the line too long");
    property p_one_bit;
        mic_oe && $past(mic_oe) |-> $stable(mic_dat);
    endproperty
    a_one_bit: assert property (p_one_bit)
        else $error("right bit changed while driven");
    property p_left_bit;
        peer_oe && $past(peer_oe) |-> $stable(peer_dat);
    endproperty
    a_left_bit: assert property (p_left_bit)
        else $error("left bit changed while driven");
    property p_drive_len;
        $rose(mic_oe) |-> mic_oe [*8];
    endproperty
    a_drive_len: assert property (p_drive_len)
        else $error("right drive window too short");
    // Margin over the 500-cycle sleep threshold covers the sync delay
    property p_sleep_release;
        idle_q >= 10'h258 |-> !mic_oe && !peer_oe;
    endproperty
    a_sleep_release: assert property (p_sleep_release)
        else $error("line driven with the clock stopped");
    property p_bclk_half;
        bclk != $past(bclk) |=> $stable(bclk) [*8];
    endproperty
    a_bclk_half: assert property (p_bclk_half)
        else $error("bit clock half period too short");
endmodule // pdm_link_props

// ### pdm_microphone_output_port_tb.sv
// Self-checking bench: codec facing a right and a left microphone
`timescale 1ns/100ps
module pdm_microphone_output_port_tb;
    import pdm_pkg::*;
    localparam int WAKE_N  = 200;
    localparam int START_N = 400;
    localparam int DEC_N   = 8;

    logic                clk_sys   = 1'b0;
    logic                srst      = 1'b1;
    mode_t               mode_req  = MODE_STD;
    logic [SAMPLE_W-1:0] smp_r     = 16'h0000;
    logic [SAMPLE_W-1:0] smp_l     = 16'h0000;
    logic                valid     = 1'b0;
    logic [1:0]          rdy;
    logic [1:0]          lp;
    logic [1:0]          slp;
    logic [1:0]          stl;
    logic                bit_left;
    logic                bit_right;
    logic                bit_valid;
    logic                pcm_valid;
    logic [PCM_W-1:0]    pcm_left;
    logic [PCM_W-1:0]    pcm_right;
    logic [31:0]         rng       = 32'h5E85DE57;
    int                  num_errors = 0;
    int                  n_checks   = 0;
    int                  n_bits     = 0;
    int                  n_pcm      = 0;

    //--------------------------------------------------------------------
    // Right end on link, left end on link2 sharing clock and line
    //--------------------------------------------------------------------
    pdm_link_if link ();
    pdm_link_if link2 ();
    assign link2.bclk     = link.bclk;
    assign link2.peer_oe  = 1'b0;
    assign link2.peer_dat = 1'b0;
    assign link.peer_oe   = link2.mic_oe;
    assign link.peer_dat  = link2.mic_dat;

    pdm_mic #(.WAKE_COUNT(WAKE_N), .STARTUP_COUNT(START_N)) pdm_mic_inst (
        .clk_sys(clk_sys), .srst(srst), .select_pin(1'b0),
        .sample_data(smp_r), .sample_valid(valid), .sample_ready(rdy[0]),
        .link(link.mic), .low_power_listening_state(lp[0]),
        .sleeping(slp[0]), .settled(stl[0]));
    pdm_mic #(.WAKE_COUNT(WAKE_N), .STARTUP_COUNT(START_N)) pdm_mic_l_inst (
        .clk_sys(clk_sys), .srst(srst), .select_pin(1'b1),
        .sample_data(smp_l), .sample_valid(valid), .sample_ready(rdy[1]),
        .link(link2.mic), .low_power_listening_state(lp[1]),
        .sleeping(slp[1]), .settled(stl[1]));
    pdm_codec #(.DECIM_LEN(DEC_N)) pdm_codec_inst (
        .clk_sys(clk_sys), .srst(srst), .mode_req(mode_req),
        .link(link.codec), .bit_left(bit_left), .bit_right(bit_right),
        .bit_valid(bit_valid), .pcm_left(pcm_left),
        .pcm_right(pcm_right), .pcm_valid(pcm_valid));
    pdm_link_props pdm_link_props_inst (
        .clk_sys(clk_sys), .srst(srst), .bclk(link.bclk),
        .mic_dat(link.mic_dat), .mic_oe(link.mic_oe),
        .peer_dat(link.peer_dat), .peer_oe(link.peer_oe),
        .clash(link.clash));

    always #5 clk_sys = ~clk_sys;

    // Slot pairs and decimated words seen, for the cadence check
    always @(negedge clk_sys) begin
        n_bits += int'(bit_valid === 1'b1);
        n_pcm  += int'(pcm_valid === 1'b1);
    end

    //--------------------------------------------------------------------
    // Helpers
    //--------------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic logic dense(input logic [15:0] v);
        return !v[15] && v != 16'h0000;
    endfunction

    task automatic check(input string what, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %b, seen %b", what, exp, got);
        end
    endtask

    task automatic summarize;
        if (num_errors == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    task automatic wait_settled(output int t);
        t = 0;
        while (stl !== 2'b11 && t < 3000) begin
            @(negedge clk_sys);
            t++;
        end
    endtask

    // First 16 bits are skipped so stale buffered words drain out
    task automatic measure(input logic [15:0] v, output int o_r, output int o_l);
        o_r = 0;
        o_l = 0;
        smp_r = v;
        smp_l = -v;
        for (int i = 0; i < 80; i++) begin
            do @(negedge clk_sys); while (bit_valid !== 1'b1);
            if (i >= 16) begin
                o_r += int'(bit_right);
                o_l += int'(bit_left);
            end
        end
    endtask

    //--------------------------------------------------------------------
    // Main sequence
    //--------------------------------------------------------------------
    initial begin
        int t;
        int o_r;
        int o_l;
        logic [15:0] v;
        cyc(3);
        srst = 1'b0;
        check("ready after reset", 1'b1, &rdy);
        check("oe after reset", 1'b0, link.mic_oe);
        check("settled after reset", 1'b0, stl[0]);
        valid = 1'b1;
        smp_r = rng[15:0];
        smp_l = rng[31:16];
        cyc(12);
        check("ready with buffer full", 1'b0, |rdy);
        wait_settled(t);
        check("startup time", 1'b1, (t + 12) inside {[START_N:START_N+40]});
        check("standard mode", 1'b0, lp[0]);
        for (int k = 0; k < 4; k++) begin
            rng = xs(rng);
            v = {1'b0, rng[14:0]} | 16'h4000;
            if (rng[15]) v = -v;
            if (k == 0) v = 16'h7FFF;
            if (k == 1) v = 16'h8000;
            measure(v, o_r, o_l);
            check("right density", dense(v), o_r > 32);
            check("left density", dense(-v), o_l > 32);
        end
        measure(16'h0000, o_r, o_l);
        check("zero density", 1'b1, o_r inside {[24:40]});
        mode_req = MODE_LP;
        cyc(2000);
        check("low-power right", 1'b1, lp[0]);
        check("low-power left", 1'b1, lp[1]);
        mode_req = MODE_SLEEP;
        cyc(700);
        check("sleep state", 1'b1, &slp);
        check("sleep unsettled", 1'b0, stl[0]);
        check("sleep released", 1'b0, link.mic_oe | link.peer_oe);
        mode_req = MODE_STD;
        wait_settled(t);
        check("wake time", 1'b1, t inside {[WAKE_N:WAKE_N+60]});
        check("standard after wake", 1'b0, lp[0]);
        measure(16'h7FFF, o_r, o_l);
        check("resumed density", 1'b1, o_r > 32);
        check("pcm sign", 1'b0, pcm_right[PCM_W-1]);
        t = n_bits / DEC_N - n_pcm;
        check("pcm cadence", 1'b1, t inside {[0:1]});
        summarize;
    end

    initial begin
        repeat (80000) @(posedge clk_sys);
        num_errors++;
        summarize;
    end
endmodule // pdm_microphone_output_port_tb
